// ---- hdl/scpm_pin_mux.sv ----
// Mode-dependent routing of the upper connector pins of a storage card
//
// What this block does
// - PC Card modes ignore the cable-select input completely.
// - DMA acknowledge is ignored, even floating, while no DMA runs.
// - IDE without burst: write line is I/O write, ready line is IORDY.
// - IDE write burst: write line is STOP, ready line is DMA-ready.
// - IDE read burst: write line is STOP, ready line is data strobe.
// - Upper byte lane and odd card enable matter only for word access.
// - True IDE mode is supported besides both PC Card modes.
// - IDE uses only three low address lines to pick a task register.
// - IDE status lines become open-drain diagnostic and active handshakes.
`timescale 1ns/1ps
module scpm_pin_mux (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  // Connector inputs
  input  wire logic                    interface_mode_select_n,
  input  wire logic                    cable_select_in_n,
  input  wire logic                    reg_dma_ack_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    mem_write_enable_n,
  input  wire logic                    odd_byte_card_enable_n,
  input  wire logic [10:0]             address_in,
  // Connector pin 37
  output logic                         ready_irq_o,
  output logic                         ready_irq_oe,
  // Connector pin 42
  output logic                         wait_ready_o,
  output logic                         wait_ready_oe,
  // Connector pin 43
  output logic                         input_port_ack_o,
  output logic                         input_port_ack_oe,
  // Connector pin 45
  output logic                         battery_voltage_detect_two_o,
  output logic                         battery_voltage_detect_two_oe,
  input  wire logic                    battery_voltage_detect_two_i,
  // Connector pin 46
  output logic                         battery_voltage_detect_one_o,
  output logic                         battery_voltage_detect_one_oe,
  input  wire logic                    battery_voltage_detect_one_i,
  // Core side
  input  wire logic                    io_mode_cfg,
  input  wire logic                    card_ready,
  input  wire logic                    io_interrupt_request_n,
  input  wire logic                    ide_interrupt,
  input  wire logic                    card_wait_n,
  input  wire logic                    ide_io_ready,
  input  wire logic                    input_port_ack_n,
  input  wire logic                    ide_dma_request,
  input  wire logic                    status_changed_out_n,
  input  wire logic                    binary_audio_out_n,
  input  wire logic                    pass_diag_drive_n,
  input  wire logic                    disk_active_drive_n,
  input  wire logic                    dma_active,
  input  wire logic                    udma_write_active,
  input  wire logic                    udma_read_active,
  input  wire logic                    udma_dma_ready_n,
  input  wire logic                    udma_data_strobe,
  output logic                         mode_valid,
  output scpm_pkg::scpm_mode_e         mode,
  output logic                         io_write_n,
  output logic                         udma_stop,
  output logic                         dma_ack_n,
  output logic                         reg_select_n,
  output logic                         mem_write_n,
  output logic                         device_is_slave,
  output logic                         word_access,
  output logic [2:0]                   task_reg_index,
  output logic [10:0]                  pc_address,
  output logic                         pass_diag_seen_n,
  output logic                         disk_active_seen_n
);

  scpm_sync_if sync_bus ();

  logic [scpm_pkg::SYNC_W-1:0] pin_s;
  logic [2:0]                  settle_ff;
  logic                        mode_valid_ff;
  scpm_pkg::scpm_mode_e        mode_ff;
  scpm_pkg::scpm_burst_e       burst;
  logic                        is_ide;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  assign sync_bus.raw = {address_in, battery_voltage_detect_two_i, battery_voltage_detect_one_i,
                         odd_byte_card_enable_n, mem_write_enable_n, write_strobe_n,
                         reg_dma_ack_n, cable_select_in_n, interface_mode_select_n};

  scpm_pin_sync u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .sync_bus (sync_bus.sampler)
  );

  assign pin_s = sync_bus.clean;

  // ---------------------------------------------------------------
  // Mode capture
  // ---------------------------------------------------------------
  // mode after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_ff <= 3'h0;
    end else if (settle_ff != scpm_pkg::MODE_SETTLE) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_valid_ff <= 1'b0;
      mode_ff       <= scpm_pkg::SCPM_MODE_MEM;
    end else if (!mode_valid_ff && settle_ff == scpm_pkg::MODE_SETTLE) begin
      mode_valid_ff <= 1'b1;
      if (!pin_s[scpm_pkg::BIT_MODE_SEL]) begin
        mode_ff <= scpm_pkg::SCPM_MODE_IDE;
      end else if (io_mode_cfg) begin
        mode_ff <= scpm_pkg::SCPM_MODE_IO;
      end else begin
        mode_ff <= scpm_pkg::SCPM_MODE_MEM;
      end
    end else if (mode_valid_ff && mode_ff != scpm_pkg::SCPM_MODE_IDE) begin
      mode_ff <= io_mode_cfg ? scpm_pkg::SCPM_MODE_IO : scpm_pkg::SCPM_MODE_MEM;
    end
  end

  assign mode_valid = mode_valid_ff;
  assign mode       = mode_ff;
  assign is_ide     = mode_valid_ff && (mode_ff == scpm_pkg::SCPM_MODE_IDE);

  always_comb begin
    if (!is_ide) begin
      burst = scpm_pkg::SCPM_BURST_NONE;
    end else if (udma_write_active) begin
      burst = scpm_pkg::SCPM_BURST_WRITE;
    end else if (udma_read_active) begin
      burst = scpm_pkg::SCPM_BURST_READ;
    end else begin
      burst = scpm_pkg::SCPM_BURST_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Inputs toward the core
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_write_n      <= 1'b1;
      udma_stop       <= 1'b0;
      dma_ack_n       <= 1'b1;
      reg_select_n    <= 1'b1;
      mem_write_n     <= 1'b1;
      device_is_slave <= 1'b0;
    end else begin
      io_write_n   <= (burst == scpm_pkg::SCPM_BURST_NONE) ? pin_s[scpm_pkg::BIT_IOWR] : 1'b1;
      udma_stop    <= (burst != scpm_pkg::SCPM_BURST_NONE) && pin_s[scpm_pkg::BIT_IOWR];
      dma_ack_n    <= (is_ide && dma_active) ? pin_s[scpm_pkg::BIT_DMACK_REG] : 1'b1;
      reg_select_n <= (mode_valid_ff && !is_ide) ? pin_s[scpm_pkg::BIT_DMACK_REG] : 1'b1;
      mem_write_n  <= (mode_valid_ff && !is_ide) ? pin_s[scpm_pkg::BIT_WE] : 1'b1;
      device_is_slave <= is_ide && pin_s[scpm_pkg::BIT_CABLE_SELECT_IN];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_access    <= 1'b0;
      task_reg_index <= 3'h0;
      pc_address     <= 11'h000;
    end else begin
      // odd enable only for word access
      word_access    <= mode_valid_ff && !pin_s[scpm_pkg::BIT_CE_ODD];
      task_reg_index <= pin_s[scpm_pkg::BIT_ADDR_LO +: scpm_pkg::TASK_IDX_W];
      pc_address     <= is_ide ? 11'h000 : pin_s[scpm_pkg::BIT_ADDR_LO +: scpm_pkg::ADDR_W];
    end
  end

  // ---------------------------------------------------------------
  // Connector outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_irq_o       <= 1'b0;
      ready_irq_oe      <= 1'b0;
      input_port_ack_o  <= 1'b1;
      input_port_ack_oe <= 1'b0;
    end else begin
      ready_irq_oe      <= mode_valid_ff;
      input_port_ack_oe <= mode_valid_ff;
      case (mode_ff)
        scpm_pkg::SCPM_MODE_MEM: begin
          ready_irq_o      <= card_ready;
          input_port_ack_o <= input_port_ack_n;
        end
        scpm_pkg::SCPM_MODE_IO: begin
          ready_irq_o      <= io_interrupt_request_n;
          input_port_ack_o <= input_port_ack_n;
        end
        scpm_pkg::SCPM_MODE_IDE: begin
          ready_irq_o      <= ide_interrupt;
          input_port_ack_o <= ide_dma_request;
        end
        default: begin
          ready_irq_o      <= 1'b0;
          input_port_ack_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ready_o  <= 1'b1;
      wait_ready_oe <= 1'b0;
    end else if (!mode_valid_ff) begin
      wait_ready_o  <= 1'b1;
      wait_ready_oe <= 1'b0;
    end else if (!is_ide) begin
      wait_ready_o  <= card_wait_n;
      wait_ready_oe <= 1'b1;
    end else begin
      case (burst)
        scpm_pkg::SCPM_BURST_WRITE: begin
          wait_ready_o  <= udma_dma_ready_n;
          wait_ready_oe <= 1'b1;
        end
        scpm_pkg::SCPM_BURST_READ: begin
          wait_ready_o  <= udma_data_strobe;
          wait_ready_oe <= 1'b1;
        end
        scpm_pkg::SCPM_BURST_NONE: begin
          wait_ready_o  <= 1'b0;
          wait_ready_oe <= !ide_io_ready;
        end
        default: begin
          wait_ready_o  <= 1'b1;
          wait_ready_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      battery_voltage_detect_two_o  <= 1'b1;
      battery_voltage_detect_two_oe <= 1'b0;
      battery_voltage_detect_one_o  <= 1'b1;
      battery_voltage_detect_one_oe <= 1'b0;
    end else begin
      case (mode_ff)
        scpm_pkg::SCPM_MODE_MEM: begin
          battery_voltage_detect_two_o  <= 1'b1;
          battery_voltage_detect_two_oe <= mode_valid_ff;
          battery_voltage_detect_one_o  <= 1'b1;
          battery_voltage_detect_one_oe <= mode_valid_ff;
        end
        scpm_pkg::SCPM_MODE_IO: begin
          battery_voltage_detect_two_o  <= binary_audio_out_n;
          battery_voltage_detect_two_oe <= mode_valid_ff;
          battery_voltage_detect_one_o  <= status_changed_out_n;
          battery_voltage_detect_one_oe <= mode_valid_ff;
        end
        scpm_pkg::SCPM_MODE_IDE: begin
          battery_voltage_detect_two_o  <= 1'b0;
          battery_voltage_detect_two_oe <= mode_valid_ff && !disk_active_drive_n;
          battery_voltage_detect_one_o  <= 1'b0;
          battery_voltage_detect_one_oe <= mode_valid_ff && !pass_diag_drive_n;
        end
        default: begin
          battery_voltage_detect_two_o  <= 1'b1;
          battery_voltage_detect_two_oe <= 1'b0;
          battery_voltage_detect_one_o  <= 1'b1;
          battery_voltage_detect_one_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pass_diag_seen_n   <= 1'b1;
      disk_active_seen_n <= 1'b1;
    end else begin
      pass_diag_seen_n   <= is_ide ? pin_s[scpm_pkg::BIT_PDIAG] : 1'b1;
      disk_active_seen_n <= is_ide ? pin_s[scpm_pkg::BIT_DASP] : 1'b1;
    end
  end

endmodule

// ---- hdl/scpm_pin_sync.sv ----
// Three-stage pin sampler with agreement filter
`timescale 1ns/1ps
module scpm_pin_sync (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  scpm_sync_if.sampler    sync_bus
);

  logic [scpm_pkg::SYNC_W-1:0] stage1_ff;
  logic [scpm_pkg::SYNC_W-1:0] stage2_ff;
  logic [scpm_pkg::SYNC_W-1:0] stage3_ff;
  logic [scpm_pkg::SYNC_W-1:0] clean_ff;
  logic [scpm_pkg::SYNC_W-1:0] nxt_clean;

  // ---------------------------------------------------------------
  // Shift chain
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_ff <= scpm_pkg::SYNC_IDLE;
      stage2_ff <= scpm_pkg::SYNC_IDLE;
      stage3_ff <= scpm_pkg::SYNC_IDLE;
    end else begin
      stage1_ff <= sync_bus.raw;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // ---------------------------------------------------------------
  // Accept a bit once stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < scpm_pkg::SYNC_W; i++) begin
      nxt_clean[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : clean_ff[i];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clean_ff <= scpm_pkg::SYNC_IDLE;
    end else begin
      clean_ff <= nxt_clean;
    end
  end

  assign sync_bus.clean = clean_ff;

endmodule

// ---- hdl/scpm_pkg.sv ----
// Shared constants and types for the card pin mode multiplexer
package scpm_pkg;

  // ---------------------------------------------------------------
  // Synchronised input bundle layout
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W        = 19;
  localparam int unsigned BIT_MODE_SEL  = 0;
  localparam int unsigned BIT_CABLE_SELECT_IN      = 1;
  localparam int unsigned BIT_DMACK_REG = 2;
  localparam int unsigned BIT_IOWR      = 3;
  localparam int unsigned BIT_WE        = 4;
  localparam int unsigned BIT_CE_ODD    = 5;
  localparam int unsigned BIT_PDIAG     = 6;
  localparam int unsigned BIT_DASP      = 7;
  localparam int unsigned BIT_ADDR_LO   = 8;
  localparam int unsigned ADDR_W        = 11;
  localparam int unsigned TASK_IDX_W    = 3;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_IDLE     = 19'h000ff;
  localparam logic [2:0]        MODE_SETTLE   = 3'h5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCPM_MODE_MEM,
    SCPM_MODE_IO,
    SCPM_MODE_IDE
  } scpm_mode_e;

  typedef enum logic [1:0] {
    SCPM_BURST_NONE,
    SCPM_BURST_WRITE,
    SCPM_BURST_READ
  } scpm_burst_e;

endpackage

// ---- hdl/scpm_sync_if.sv ----
// Bundle between the pin sampler and the multiplexer
`timescale 1ns/1ps
interface scpm_sync_if;
  logic [scpm_pkg::SYNC_W-1:0] raw;
  logic [scpm_pkg::SYNC_W-1:0] clean;

  modport sampler (input raw, output clean);
  modport mux     (output raw, input clean);
endinterface

// ---- test/scpm_host_model.sv ----
// Host side model driving the card connector inputs
`timescale 1ns/1ps
module scpm_host_model (
  input  wire logic        core_clk,
  input  wire logic        ide,
  input  wire logic [16:0] knob,
  input  wire logic        battery_voltage_detect_one_o,
  input  wire logic        battery_voltage_detect_one_oe,
  output logic             battery_voltage_detect_one_i,
  input  wire logic        battery_voltage_detect_two_o,
  input  wire logic        battery_voltage_detect_two_oe,
  output logic             battery_voltage_detect_two_i,
  output logic             interface_mode_select_n,
  output logic             cable_select_in_n,
  output logic             reg_dma_ack_n,
  output logic             write_strobe_n,
  output logic             mem_write_enable_n,
  output logic             odd_byte_card_enable_n,
  output logic [10:0]      address_in
);
  assign interface_mode_select_n = !ide;
  assign cable_select_in_n = knob[16];
  assign write_strobe_n = knob[15];
  // write enable tied high in ide
  assign mem_write_enable_n = ide | !knob[15];
  assign odd_byte_card_enable_n = knob[14];
  assign address_in = ide ? {8'h00, knob[2:0]} : knob[10:0];
  assign battery_voltage_detect_one_i =
    !((battery_voltage_detect_one_oe && !battery_voltage_detect_one_o) || (ide && knob[11]));
  assign battery_voltage_detect_two_i =
    !((battery_voltage_detect_two_oe && !battery_voltage_detect_two_o) || (ide && knob[12]));
  // ack driven, or floating in card modes
  initial reg_dma_ack_n = 1'b1;
  always @(posedge core_clk) begin
    reg_dma_ack_n <= (knob[12] && !ide) ? !reg_dma_ack_n : knob[13];
  end
endmodule

// ---- test/scpm_pin_mux_chk.sv ----
// Port assertions for the card pin mode multiplexer
`timescale 1ns/1ps
module scpm_pin_mux_chk (
  input wire logic                 core_clk,
  input wire logic                 reset_n,
  input wire logic                 odd_byte_card_enable_n,
  input wire logic [10:0]          address_in,
  input wire logic                 dma_active,
  input wire logic                 udma_write_active,
  input wire logic                 udma_read_active,
  input wire logic                 udma_dma_ready_n,
  input wire logic                 udma_data_strobe,
  input wire logic                 wait_ready_o,
  input wire logic                 wait_ready_oe,
  input wire logic                 mode_valid,
  input wire scpm_pkg::scpm_mode_e mode,
  input wire logic                 io_write_n,
  input wire logic                 dma_ack_n,
  input wire logic                 reg_select_n,
  input wire logic                 mem_write_n,
  input wire logic                 device_is_slave,
  input wire logic                 word_access,
  input wire logic [2:0]           task_reg_index,
  input wire logic [10:0]          pc_address
);
  localparam scpm_pkg::scpm_mode_e IDE_M = scpm_pkg::SCPM_MODE_IDE;

  logic [2:0] settle_cnt_ff;
  logic [1:0] mv_hist_ff;
  logic       mode_up;

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_ff <= 3'h0;
      mv_hist_ff    <= 2'h0;
    end else begin
      mv_hist_ff <= {mv_hist_ff[0], mode_valid};
      if (settle_cnt_ff != 3'h7) begin
        settle_cnt_ff <= settle_cnt_ff + 3'h1;
      end
    end
  end
  assign mode_up = mode_valid && mv_hist_ff[1];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence wr_hold;
    mode_up && mode == IDE_M && udma_write_active ##1 udma_write_active;
  endsequence
  sequence rd_hold;
    mode_up && mode == IDE_M && udma_read_active && !udma_write_active
      ##1 udma_read_active && !udma_write_active;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_cable_select_in_ignored: assert property (
    mode_up && mode != IDE_M |-> !device_is_slave)
    else $error("slave flag set in card mode");
  chk_dmack_ignored: assert property (
    mode_up && (mode != IDE_M || !dma_active && !$past(dma_active)) |-> dma_ack_n)
    else $error("dma ack passed while no dma");
  chk_ide_forced: assert property (
    mode_up && mode == IDE_M |-> mem_write_n && reg_select_n && pc_address == 11'h000)
    else $error("card mode lines active in ide");
  chk_wr_ready: assert property (
    wr_hold |-> wait_ready_oe && wait_ready_o == $past(udma_dma_ready_n))
    else $error("ready line not dma ready");
  chk_rd_strobe: assert property (
    rd_hold |-> wait_ready_oe && wait_ready_o == $past(udma_data_strobe))
    else $error("ready line not data strobe");
  chk_burst_iowr: assert property (
    mode_up && mode == IDE_M && $past(udma_write_active || udma_read_active) |-> io_write_n)
    else $error("io write seen in burst");
  chk_mode_held: assert property (
    mode_valid && $past(mode_valid) |-> (mode == IDE_M) == $past(mode == IDE_M))
    else $error("mode changed in session");
  chk_settle_early: assert property (
    settle_cnt_ff < 3'h5 |-> !mode_valid)
    else $error("mode valid too early");
  chk_settle_late: assert property (
    settle_cnt_ff == 3'h7 |-> mode_valid)
    else $error("mode valid too late");
  chk_word_lane: assert property (
    ($stable(odd_byte_card_enable_n) && mode_valid) [*8]
      |-> word_access == !odd_byte_card_enable_n)
    else $error("word access wrong");
  chk_task_index: assert property (
    ($stable(address_in) && mode_valid) [*8] |-> task_reg_index == address_in[2:0])
    else $error("task index wrong");
endmodule

// ---- test/tb_scpm_pin_mux.sv ----
// Self-checking bench for the card pin mode multiplexer
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); \
  end \
end
module tb_scpm_pin_mux;
  int                   error_cnt;
  int                   checks_done;
  int                   seed;
  logic                 core_clk, reset_n, ide, a25, stop, odd_n, dmack_n, flt, diag_pull;
  logic [16:0]          knob, core_in;
  logic [10:0]          addr, address_in, pc_address;
  logic [2:0]           task_reg_index;
  logic                 interface_mode_select_n, cable_select_in_n, reg_dma_ack_n;
  logic                 write_strobe_n, mem_write_enable_n, odd_byte_card_enable_n;
  logic                 ready_irq_o, ready_irq_oe, wait_ready_o, wait_ready_oe;
  logic                 input_port_ack_o, input_port_ack_oe;
  logic                 battery_voltage_detect_two_o, battery_voltage_detect_two_oe;
  logic                 battery_voltage_detect_two_i, battery_voltage_detect_one_i;
  logic                 battery_voltage_detect_one_o, battery_voltage_detect_one_oe;
  logic                 io_mode_cfg, card_ready, io_interrupt_request_n, ide_interrupt;
  logic                 card_wait_n, ide_io_ready, input_port_ack_n, ide_dma_request;
  logic                 status_changed_out_n, binary_audio_out_n, pass_diag_drive_n;
  logic                 disk_active_drive_n, dma_active, udma_write_active, udma_read_active;
  logic                 udma_dma_ready_n, udma_data_strobe, mode_valid, io_write_n, udma_stop;
  logic                 dma_ack_n, reg_select_n, mem_write_n, device_is_slave, word_access;
  logic                 pass_diag_seen_n, disk_active_seen_n;
  scpm_pkg::scpm_mode_e mode;

  assign {a25, stop, odd_n, dmack_n, flt, diag_pull, addr} = knob;
  assign {io_mode_cfg, card_ready, io_interrupt_request_n, ide_interrupt, card_wait_n,
          ide_io_ready, input_port_ack_n, ide_dma_request, status_changed_out_n,
          binary_audio_out_n, pass_diag_drive_n, disk_active_drive_n, dma_active,
          udma_write_active, udma_read_active, udma_dma_ready_n, udma_data_strobe} = core_in;
  scpm_pin_mux uut (.*);
  scpm_host_model host (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end

  // ---------------------------------------------------------------
  // Expectations and drivers
  // ---------------------------------------------------------------
  function automatic scpm_pkg::scpm_mode_e exp_mode(logic pin_ide, logic cfg);
    if (pin_ide) begin
      return scpm_pkg::SCPM_MODE_IDE;
    end
    return cfg ? scpm_pkg::SCPM_MODE_IO : scpm_pkg::SCPM_MODE_MEM;
  endfunction

  function automatic logic exp_ack(logic pin_ide, logic act, logic pin);
    return (pin_ide && act) ? pin : 1'b1;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic pin_ide);
    int k;
    @(posedge core_clk);
    ide     <= pin_ide;
    reset_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    for (k = 0; k < 20 && mode_valid !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    if (mode_valid !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic round(input logic [16:0] k, input logic [16:0] c);
    @(posedge core_clk);
    knob    <= k;
    core_in <= c;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    if (ide) begin
      `CHK(task_reg_index, addr[2:0])
      `CHK(device_is_slave, a25)
      `CHK(mem_write_n, 1'b1)
      `CHK(pass_diag_seen_n, !(diag_pull || !pass_diag_drive_n))
      `CHK(disk_active_seen_n, !(flt || !disk_active_drive_n))
      `CHK(battery_voltage_detect_two_oe, !disk_active_drive_n)
      `CHK(battery_voltage_detect_one_oe, !pass_diag_drive_n)
      `CHK(battery_voltage_detect_two_o | battery_voltage_detect_one_o, 1'b0)
      `CHK(ready_irq_o, ide_interrupt)
      `CHK(input_port_ack_o, ide_dma_request)
      if (udma_write_active || udma_read_active) begin
        `CHK(io_write_n, 1'b1)
        `CHK(udma_stop, stop)
        `CHK(wait_ready_oe, 1'b1)
        `CHK(wait_ready_o, udma_write_active ? udma_dma_ready_n : udma_data_strobe)
      end else begin
        `CHK(io_write_n, stop)
        `CHK(wait_ready_oe, !ide_io_ready)
        `CHK(wait_ready_o | udma_stop, 1'b0)
      end
    end else begin
      `CHK(device_is_slave, 1'b0)
      `CHK(mem_write_n, !stop)
      `CHK(pass_diag_seen_n & disk_active_seen_n, 1'b1)
      `CHK(ready_irq_o, io_mode_cfg ? io_interrupt_request_n : card_ready)
      `CHK(input_port_ack_o, input_port_ack_n)
      `CHK(wait_ready_oe, 1'b1)
      `CHK(wait_ready_o, card_wait_n)
      `CHK(battery_voltage_detect_two_o, io_mode_cfg ? binary_audio_out_n : 1'b1)
      `CHK(battery_voltage_detect_one_o, io_mode_cfg ? status_changed_out_n : 1'b1)
      `CHK(battery_voltage_detect_two_oe & battery_voltage_detect_one_oe, 1'b1)
      if (!flt) `CHK(reg_select_n, dmack_n)
    end
    `CHK(ready_irq_oe & input_port_ack_oe & mode_valid, 1'b1)
    `CHK(mode, exp_mode(ide, io_mode_cfg))
    `CHK(dma_ack_n, exp_ack(ide, dma_active, dmack_n))
    `CHK(pc_address, ide ? 11'h000 : addr)
    `CHK(word_access, !odd_n)
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed        = 32'h6c73ba9c;
    error_cnt   = 0;
    checks_done = 0;
    reset_n     = 1'b0;
    ide         = 1'b1;
    knob        = 17'h00000;
    core_in     = 17'h00000;
    do_reset(1'b1);
    `CHK(mode, scpm_pkg::SCPM_MODE_IDE)
    round(17'h1ffff, 17'h1ffff);
    round(17'h00000, 17'h0000c);
    repeat (60) begin
      round(17'($random(seed)), 17'($random(seed)));
    end
    $display("test true ide done");
    do_reset(1'b0);
    round(17'h1ffff, 17'h1ffff);
    repeat (40) begin
      round(17'($random(seed)), 17'($random(seed)));
    end
    $display("test card modes done");
    tally_and_finish();
  end
endmodule

bind scpm_pin_mux scpm_pin_mux_chk u_chk (.*);
